// ===== logic/gsr_pkg.sv
`default_nettype none

package gsr_pkg;

	// ****************************************
	// Register port geometry and map
	// ****************************************
	localparam int         ADDR_W     = 4;
	localparam int         DATA_W     = 8;
	localparam logic [3:0] REG_STB    = 4'h0;
	localparam logic [3:0] REG_SRE    = 4'h1;
	localparam logic [3:0] REG_ESR    = 4'h2;
	localparam logic [3:0] REG_ESE    = 4'h3;
	localparam logic [3:0] REG_OPC    = 4'h4;
	localparam logic [3:0] REG_OPV    = 4'h5;
	localparam logic [3:0] REG_OPN    = 4'h6;
	localparam logic [3:0] REG_ERC    = 4'h7;
	localparam logic [3:0] REG_ERV    = 4'h8;
	localparam logic [3:0] REG_ERN    = 4'h9;
	localparam logic [3:0] REG_STATE  = 4'hA;
	localparam logic [3:0] REG_CTRL   = 4'hB;
	localparam logic [7:0] REG_RST    = 8'h00;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int STB_ERR_BIT   = 2;
	localparam int STB_MAV_BIT   = 4;
	localparam int STB_ESB_BIT   = 5;
	localparam int STB_RQS_BIT   = 6;
	localparam int STB_OPS_BIT   = 7;
	localparam int ESR_CME_BIT   = 5;
	localparam int CTRL_CLS_BIT  = 0;
	localparam int CTRL_ABT_BIT  = 1;
	localparam int ST_REMOTE_BIT = 0;
	localparam int ST_LOCK_BIT   = 1;
	localparam int ST_LISTEN_BIT = 2;
	localparam int ST_TALK_BIT   = 3;
	localparam int ST_SPOLL_BIT  = 4;
	localparam int ST_RESP_BIT   = 5;
	localparam int ST_BUSY_BIT   = 6;

	// ****************************************
	// Bus command bytes (ATN asserted)
	// ****************************************
	localparam logic [7:0] CMD_GTL    = 8'h01;
	localparam logic [7:0] CMD_SDC    = 8'h04;
	localparam logic [7:0] CMD_LLO    = 8'h11;
	localparam logic [7:0] CMD_DCL    = 8'h14;
	localparam logic [7:0] CMD_SPE    = 8'h18;
	localparam logic [7:0] CMD_SPD    = 8'h19;
	localparam logic [7:0] CMD_UNL    = 8'h3F;
	localparam logic [7:0] CMD_UNT    = 8'h5F;
	localparam logic [2:0] LAG_PFX    = 3'h1;
	localparam logic [2:0] TAG_PFX    = 3'h2;
	localparam logic [7:0] CMD_MASK   = 8'h7F;

	// ****************************************
	// Message characters and mnemonics
	// ****************************************
	localparam logic [7:0]  CH_STAR   = 8'h2A;
	localparam logic [7:0]  CH_QMARK  = 8'h3F;
	localparam logic [7:0]  CH_SEMI   = 8'h3B;
	localparam logic [7:0]  CH_SPACE  = 8'h20;
	localparam logic [7:0]  CH_CR     = 8'h0D;
	localparam logic [7:0]  CH_LF     = 8'h0A;
	localparam logic [7:0]  CH_ZERO   = 8'h30;
	localparam logic [7:0]  CH_NINE   = 8'h39;
	localparam logic [23:0] MN_CLS    = 24'h434C53;
	localparam logic [23:0] MN_ESR    = 24'h455352;
	localparam logic [23:0] MN_ESE    = 24'h455345;
	localparam logic [23:0] MN_SRE    = 24'h535245;
	localparam logic [23:0] MN_STB    = 24'h535442;
	localparam logic [7:0]  MSG_MAX   = 8'hFF;
	localparam logic [11:0] ARG_MAX   = 12'h0FF;
	localparam logic [3:0]  DEC_BASE  = 4'hA;

	typedef enum logic [1:0] {PS_IDLE, PS_MNEM, PS_ARG, PS_SKIP} gsr_pst_t;

endpackage : gsr_pkg

`default_nettype wire

// ===== logic/gsr_remote_status.sv
`timescale 1ns/10ps
`default_nettype none

module gsr_remote_status
	import gsr_pkg::*;
#(
	parameter int SYNC_W = 5
)(
	input  wire logic                      clk_sys,
	input  wire logic                      resetn,
	input  wire logic [gsr_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [gsr_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output var  logic [gsr_pkg::DATA_W-1:0] reg_rdata_ff,
	input  wire logic [4:0]                dev_addr,
	input  wire logic                      bus_ren_n,
	input  wire logic                      bus_ifc_n,
	input  wire logic                      local_key,
	input  wire logic                      remote_key,
	input  wire logic                      key_press,
	input  wire logic                      rx_valid,
	input  wire logic [7:0]                rx_data,
	input  wire logic                      rx_atn,
	input  wire logic                      link_atn,
	input  wire logic                      tx_ready,
	output var  logic                      tx_valid_ff,
	output var  logic [7:0]                tx_data_ff,
	output var  logic                      tx_last_ff,
	output var  logic                      srq_o_ff,
	output var  logic                      srq_oe_n_ff,
	output var  logic                      remote_led_ff,
	output var  logic                      lockout_ff,
	output var  logic                      key_accept_ff,
	input  wire logic [7:0]                std_evt,
	input  wire logic [7:0]                op_cond,
	input  wire logic [7:0]                err_cond
);
	import gsr_pkg::*;

	// ****************************************
	// Declarations
	// ****************************************
	logic [SYNC_W-1:0] sync1_ff;
	logic [SYNC_W-1:0] sync2_ff;
	logic [SYNC_W-1:0] prev_ff;
	logic              ren;
	logic              ifc;
	logic              ren_rise;
	logic              local_rise;
	logic              remote_rise;
	logic              key_rise;
	logic              listen_ff;
	logic              talk_ff;
	logic              spoll_ff;
	logic              spoll_sent_ff;
	gsr_pst_t          pst_ff;
	logic [7:0]        len_ff;
	logic [23:0]       mnem_ff;
	logic              qry_ff;
	logic [7:0]        arg_ff;
	logic [11:0]       nxt_arg;
	logic [7:0]        esr_ff;
	logic [7:0]        ese_ff;
	logic [7:0]        sre_ff;
	logic [7:0]        opv_ff;
	logic [7:0]        opn_ff;
	logic [7:0]        erv_ff;
	logic [7:0]        ern_ff;
	logic [7:0]        opc_prev_ff;
	logic [7:0]        erc_prev_ff;
	logic [7:0]        resp_val_ff;
	logic              resp_pend_ff;
	logic [7:0]        cmd7;
	logic              atn_byte;
	logic              dat;
	logic              term;
	logic              is_mla;
	logic              is_mta;
	logic              other_ta;
	logic              dcl_exec;
	logic              gtl_exec;
	logic              clr_all;
	logic              exec;
	logic              cls_exec;
	logic              esr_q;
	logic              known;
	logic              qry_hit;
	logic [7:0]        qry_val;
	logic              ovf;
	logic              ctrl_wr;
	logic              ctrl_cls;
	logic              ctrl_abt;
	logic              rd_esr;
	logic              rd_opv;
	logic              rd_erv;
	logic [7:0]        stb;
	logic              mss;
	logic              tx_start;
	logic              tx_raw;
	logic [7:0]        tx_val;

	// ****************************************
	// Pin synchronisers and edges
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			prev_ff  <= '0;
		end else begin
			sync1_ff <= {key_press, remote_key, local_key, ~bus_ifc_n, ~bus_ren_n};
			sync2_ff <= sync1_ff;
			prev_ff  <= sync2_ff;
		end
	end

	assign ren         = sync2_ff[0];
	assign ifc         = sync2_ff[1];
	assign ren_rise    = sync2_ff[0] & ~prev_ff[0];
	assign local_rise  = sync2_ff[2] & ~prev_ff[2];
	assign remote_rise = sync2_ff[3] & ~prev_ff[3];
	assign key_rise    = sync2_ff[4] & ~prev_ff[4];

	// ****************************************
	// Bus command decode
	// ****************************************
	// Commands only count when sent with ATN asserted
	assign cmd7     = rx_data & CMD_MASK;
	assign atn_byte = rx_valid & rx_atn;
	assign is_mla   = atn_byte && (cmd7 == {LAG_PFX, dev_addr});
	assign is_mta   = atn_byte && (cmd7 == {TAG_PFX, dev_addr});
	assign other_ta = atn_byte && (cmd7[6:5] == TAG_PFX[1:0]) && (cmd7 != CMD_UNT) && !is_mta;
	assign dcl_exec = atn_byte && ((cmd7 == CMD_DCL) || ((cmd7 == CMD_SDC) && listen_ff));
	assign gtl_exec = atn_byte && (cmd7 == CMD_GTL) && listen_ff;
	assign clr_all  = ifc || dcl_exec;

	// ****************************************
	// Addressing and serial poll
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (!resetn || ifc) begin
			listen_ff <= 1'b0;
			talk_ff   <= 1'b0;
		end else if (is_mla) begin
			listen_ff <= 1'b1;
			talk_ff   <= 1'b0;
		end else if (is_mta) begin
			talk_ff   <= 1'b1;
			listen_ff <= 1'b0;
		end else if (atn_byte && (cmd7 == CMD_UNL)) begin
			listen_ff <= 1'b0;
		end else if (atn_byte && (cmd7 == CMD_UNT || other_ta)) begin
			talk_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn || ifc) begin
			spoll_ff      <= 1'b0;
			spoll_sent_ff <= 1'b0;
		end else begin
			if (atn_byte && cmd7 == CMD_SPE) begin
				spoll_ff <= 1'b1;
			end else if (atn_byte && cmd7 == CMD_SPD) begin
				spoll_ff <= 1'b0;
			end
			if (is_mta || (atn_byte && cmd7 == CMD_SPE)) begin
				spoll_sent_ff <= 1'b0;
			end else if (tx_start && tx_raw) begin
				spoll_sent_ff <= 1'b1;
			end
		end
	end

	// ****************************************
	// Remote and local state
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (!resetn || !ren) begin
			remote_led_ff <= 1'b0;
			lockout_ff    <= 1'b0;
		end else begin
			if (atn_byte && cmd7 == CMD_LLO) begin
				lockout_ff <= 1'b1;
			end
			if (gtl_exec) begin
				remote_led_ff <= 1'b0;
			end else if (ren_rise || remote_rise) begin
				remote_led_ff <= 1'b1;
			end else if (local_rise && !lockout_ff) begin
				remote_led_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			key_accept_ff <= 1'b0;
		end else begin
			key_accept_ff <= key_rise && !remote_led_ff && !lockout_ff;
		end
	end

	// ****************************************
	// Message string parser
	// ****************************************
	assign dat  = rx_valid && !rx_atn && listen_ff;
	assign term = (rx_data == CH_LF) || (rx_data == CH_SEMI);
	assign nxt_arg = (12'(arg_ff) * 12'(DEC_BASE)) + 12'(rx_data - CH_ZERO);
	assign ovf  = dat && (rx_data != CH_LF) && (len_ff == MSG_MAX);

	always_ff @(posedge clk_sys) begin
		if (!resetn || clr_all) begin
			pst_ff  <= PS_IDLE;
			len_ff  <= REG_RST;
			mnem_ff <= '0;
			qry_ff  <= 1'b0;
			arg_ff  <= REG_RST;
		end else if (dat) begin
			if (rx_data == CH_LF) begin
				len_ff <= REG_RST;
			end else if (len_ff != MSG_MAX) begin
				len_ff <= len_ff + 8'h01;
			end
			unique case (pst_ff)
				PS_IDLE: begin
					if (rx_data == CH_STAR) begin
						pst_ff  <= PS_MNEM;
						mnem_ff <= '0;
						qry_ff  <= 1'b0;
						arg_ff  <= REG_RST;
					end else if (!term && rx_data != CH_CR && rx_data != CH_SPACE) begin
						pst_ff <= PS_SKIP;
					end
				end
				PS_MNEM: begin
					if (term) begin
						pst_ff <= PS_IDLE;
					end else if (rx_data == CH_QMARK) begin
						qry_ff <= 1'b1;
					end else if (rx_data == CH_SPACE) begin
						pst_ff <= PS_ARG;
					end else if (rx_data != CH_CR) begin
						mnem_ff <= {mnem_ff[15:0], rx_data};
					end
				end
				PS_ARG: begin
					if (term) begin
						pst_ff <= PS_IDLE;
					end else if (rx_data >= CH_ZERO && rx_data <= CH_NINE) begin
						arg_ff <= (nxt_arg > ARG_MAX) ? ARG_MAX[7:0] : nxt_arg[7:0];
					end
				end
				PS_SKIP: begin
					if (term) begin
						pst_ff <= PS_IDLE;
					end
				end
			endcase
		end
	end

	// ****************************************
	// Common command execution
	// ****************************************
	assign exec     = dat && term && (pst_ff == PS_MNEM || pst_ff == PS_ARG);
	assign cls_exec = exec && !qry_ff && (mnem_ff == MN_CLS);
	assign esr_q    = exec && qry_ff && (mnem_ff == MN_ESR);
	assign qry_hit  = exec && qry_ff &&
		(mnem_ff == MN_ESR || mnem_ff == MN_ESE || mnem_ff == MN_SRE || mnem_ff == MN_STB);
	assign known    = qry_hit || cls_exec ||
		(!qry_ff && (mnem_ff == MN_ESE || mnem_ff == MN_SRE));

	// query value is the register's binary weighted sum
	always_comb begin
		qry_val = stb;
		if (mnem_ff == MN_ESR) begin
			qry_val = esr_ff;
		end else if (mnem_ff == MN_ESE) begin
			qry_val = ese_ff;
		end else if (mnem_ff == MN_SRE) begin
			qry_val = sre_ff;
		end
	end

	assign ctrl_wr  = reg_wr && (reg_addr == REG_CTRL);
	assign ctrl_cls = ctrl_wr && reg_wdata[CTRL_CLS_BIT];
	assign ctrl_abt = ctrl_wr && reg_wdata[CTRL_ABT_BIT];
	assign rd_esr   = reg_rd && (reg_addr == REG_ESR);
	assign rd_opv   = reg_rd && (reg_addr == REG_OPV);
	assign rd_erv   = reg_rd && (reg_addr == REG_ERV);

	// ****************************************
	// Event and enable registers
	// ****************************************
	// latch events, clear by query, register read or clear-status
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			esr_ff <= REG_RST;
		end else begin
			esr_ff <= (esr_ff & ~{8{cls_exec | esr_q | ctrl_cls | rd_esr}})
				| std_evt | (8'((exec && !known) || ovf) << ESR_CME_BIT);
		end
	end

	// condition rising edges latch into events
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			opc_prev_ff <= REG_RST;
			erc_prev_ff <= REG_RST;
			opv_ff      <= REG_RST;
			erv_ff      <= REG_RST;
		end else begin
			opc_prev_ff <= op_cond;
			erc_prev_ff <= err_cond;
			opv_ff <= (opv_ff & ~{8{cls_exec | ctrl_cls | rd_opv}}) | (op_cond & ~opc_prev_ff);
			erv_ff <= (erv_ff & ~{8{cls_exec | ctrl_cls | rd_erv}}) | (err_cond & ~erc_prev_ff);
		end
	end

	// enable registers, the only writable ones besides REG_CTRL
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			ese_ff <= REG_RST;
			sre_ff <= REG_RST;
			opn_ff <= REG_RST;
			ern_ff <= REG_RST;
		end else begin
			if (reg_wr && reg_addr == REG_ESE) begin
				ese_ff <= reg_wdata;
			end else if (exec && !qry_ff && mnem_ff == MN_ESE) begin
				ese_ff <= arg_ff;
			end
			if (reg_wr && reg_addr == REG_SRE) begin
				sre_ff <= reg_wdata;
			end else if (exec && !qry_ff && mnem_ff == MN_SRE) begin
				sre_ff <= arg_ff;
			end
			if (reg_wr && reg_addr == REG_OPN) begin
				opn_ff <= reg_wdata;
			end
			if (reg_wr && reg_addr == REG_ERN) begin
				ern_ff <= reg_wdata;
			end
		end
	end

	// ****************************************
	// Status byte and service request
	// ****************************************
	// summaries and master summary
	always_comb begin
		stb               = REG_RST;
		stb[STB_ERR_BIT]  = |(erv_ff & ern_ff);
		stb[STB_MAV_BIT]  = resp_pend_ff;
		stb[STB_ESB_BIT]  = |(esr_ff & ese_ff);
		stb[STB_OPS_BIT]  = |(opv_ff & opn_ff);
		mss               = |(stb & sre_ff);
		stb[STB_RQS_BIT]  = mss;
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			srq_o_ff    <= 1'b0;
			srq_oe_n_ff <= 1'b1;
		end else begin
			srq_o_ff    <= 1'b0;
			srq_oe_n_ff <= ~mss;
		end
	end

	// ****************************************
	// Response handling
	// ****************************************
	// query only prepares; last one wins
	always_ff @(posedge clk_sys) begin
		if (!resetn || clr_all) begin
			resp_val_ff  <= REG_RST;
			resp_pend_ff <= 1'b0;
		end else if (qry_hit) begin
			resp_val_ff  <= qry_val;
			resp_pend_ff <= 1'b1;
		end else if (tx_start && !tx_raw) begin
			resp_pend_ff <= 1'b0;
		end
	end

	// send only when addressed to talk
	assign tx_raw   = spoll_ff;
	assign tx_val   = spoll_ff ? stb : resp_val_ff;
	assign tx_start = talk_ff && !link_atn && !tx_valid_ff && !clr_all &&
		(spoll_ff ? !spoll_sent_ff : resp_pend_ff);

	gsr_resp_tx u_tx (
		.clk_sys     (clk_sys),
		.resetn      (resetn),
		.start       (tx_start),
		.raw         (tx_raw),
		.value       (tx_val),
		.abort       (clr_all | ctrl_abt | !talk_ff),
		.tx_ready    (tx_ready),
		.tx_valid_ff (tx_valid_ff),
		.tx_data_ff  (tx_data_ff),
		.tx_last_ff  (tx_last_ff)
	);

	// ****************************************
	// Register read port
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (!resetn || !reg_rd) begin
			reg_rdata_ff <= REG_RST;
		end else begin
			unique case (reg_addr)
				REG_STB:   reg_rdata_ff <= stb;
				REG_SRE:   reg_rdata_ff <= sre_ff;
				REG_ESR:   reg_rdata_ff <= esr_ff;
				REG_ESE:   reg_rdata_ff <= ese_ff;
				REG_OPC:   reg_rdata_ff <= op_cond;
				REG_OPV:   reg_rdata_ff <= opv_ff;
				REG_OPN:   reg_rdata_ff <= opn_ff;
				REG_ERC:   reg_rdata_ff <= err_cond;
				REG_ERV:   reg_rdata_ff <= erv_ff;
				REG_ERN:   reg_rdata_ff <= ern_ff;
				REG_STATE: reg_rdata_ff <= {1'b0, tx_valid_ff, resp_pend_ff, spoll_ff,
					talk_ff, listen_ff, lockout_ff, remote_led_ff};
				default:   reg_rdata_ff <= REG_RST;
			endcase
		end
	end

endmodule : gsr_remote_status

`default_nettype wire

// ===== logic/gsr_resp_tx.sv
`timescale 1ns/10ps
`default_nettype none

module gsr_resp_tx
	import gsr_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic        start,
	input  wire logic        raw,
	input  wire logic [7:0]  value,
	input  wire logic        abort,
	input  wire logic        tx_ready,
	output var  logic        tx_valid_ff,
	output var  logic [7:0]  tx_data_ff,
	output var  logic        tx_last_ff
);
	import gsr_pkg::*;

	localparam int N = 5;

	logic [7:0] buf_ff [N];
	logic [2:0] cnt_ff;
	logic [2:0] idx_ff;
	logic [7:0] nxt_buf [N];
	logic [2:0] nxt_cnt;
	logic [3:0] d_h;
	logic [3:0] d_t;
	logic [3:0] d_o;
	logic [2:0] nxt_idx;

	// ****************************************
	// Response image: decimal digits then CR LF, or one raw byte
	// ****************************************
	always_comb begin
		d_h = 4'(value / 8'd100);
		d_t = 4'((value / 8'd10) % 8'd10);
		d_o = 4'(value % 8'd10);
		for (int i = 0; i < N; i++) begin
			nxt_buf[i] = CH_LF;
		end
		if (raw) begin
			nxt_buf[0] = value;
			nxt_cnt    = 3'd1;
		end else if (d_h != 4'h0) begin
			nxt_buf[0] = CH_ZERO | {4'h0, d_h};
			nxt_buf[1] = CH_ZERO | {4'h0, d_t};
			nxt_buf[2] = CH_ZERO | {4'h0, d_o};
			nxt_buf[3] = CH_CR;
			nxt_cnt    = 3'd5;
		end else if (d_t != 4'h0) begin
			nxt_buf[0] = CH_ZERO | {4'h0, d_t};
			nxt_buf[1] = CH_ZERO | {4'h0, d_o};
			nxt_buf[2] = CH_CR;
			nxt_cnt    = 3'd4;
		end else begin
			nxt_buf[0] = CH_ZERO | {4'h0, d_o};
			nxt_buf[1] = CH_CR;
			nxt_cnt    = 3'd3;
		end
		nxt_idx = idx_ff + 3'd1;
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn || abort) begin
			tx_valid_ff <= 1'b0;
			tx_data_ff  <= REG_RST;
			tx_last_ff  <= 1'b0;
			idx_ff      <= 3'd0;
			cnt_ff      <= 3'd0;
		end else if (start && !tx_valid_ff) begin
			buf_ff      <= nxt_buf;
			cnt_ff      <= nxt_cnt;
			idx_ff      <= 3'd0;
			tx_valid_ff <= 1'b1;
			tx_data_ff  <= nxt_buf[0];
			tx_last_ff  <= (nxt_cnt == 3'd1);
		end else if (tx_valid_ff && tx_ready) begin
			idx_ff <= nxt_idx;
			if (nxt_idx == cnt_ff) begin
				tx_valid_ff <= 1'b0;
				tx_last_ff  <= 1'b0;
			end else begin
				tx_data_ff <= buf_ff[nxt_idx];
				tx_last_ff <= (nxt_idx + 3'd1 == cnt_ff);
			end
		end
	end

endmodule : gsr_resp_tx

`default_nettype wire

// ===== tb/gsr_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module gsr_asserts
	import gsr_pkg::*;
#(parameter int SYNC_W = 5)(
	input wire logic       clk_sys,
	input wire logic       resetn,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata_ff,
	input wire logic       bus_ren_n,
	input wire logic       bus_ifc_n,
	input wire logic       tx_ready,
	input wire logic       tx_valid_ff,
	input wire logic [7:0] tx_data_ff,
	input wire logic       tx_last_ff,
	input wire logic       srq_oe_n_ff,
	input wire logic       remote_led_ff,
	input wire logic       lockout_ff
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	sequence s_sre_wr_rd;
		reg_wr && reg_addr == REG_SRE ##2 reg_rd && reg_addr == REG_SRE;
	endsequence
	sequence s_stb_rd;
		reg_rd && reg_addr == REG_STB ##1 $stable(srq_oe_n_ff) ##1 $stable(srq_oe_n_ff);
	endsequence
	reset_out_a: assert property (disable iff (1'h0) !resetn |=> srq_oe_n_ff && !remote_led_ff && !lockout_ff)
		else $error("outputs not at reset state");
	rd_idle_a: assert property (!reg_rd |=> reg_rdata_ff == 8'h00) else $error("read data not idle");
	enable_rw_a: assert property (s_sre_wr_rd |=> reg_rdata_ff == $past(reg_wdata, 3))
		else $error("enable readback wrong");
	rqs_srq_a: assert property (s_stb_rd |-> $past(reg_rdata_ff[STB_RQS_BIT]) != srq_oe_n_ff)
		else $error("summary bit and request line differ");
	ren_local_a: assert property (bus_ren_n [*8] |-> !remote_led_ff && !lockout_ff)
		else $error("remote without enable");
	ifc_abort_a: assert property ($fell(bus_ifc_n) |-> ##[1:8] !tx_valid_ff) else $error("send not aborted");
	tx_hold_a: assert property (tx_valid_ff && !tx_ready && bus_ifc_n |=> !tx_valid_ff || $stable(tx_data_ff))
		else $error("byte changed while stalled");
	crlf_end_a: assert property (tx_valid_ff && tx_ready && tx_data_ff == CH_CR && !tx_last_ff
		|=> tx_valid_ff && tx_data_ff == CH_LF && tx_last_ff) else $error("bad terminator");
endmodule : gsr_asserts
bind gsr_remote_status gsr_asserts #(.SYNC_W(SYNC_W)) u_gsr_asserts (.*);
`default_nettype wire

// ===== tb/gsr_host.sv
`timescale 1ns/10ps
`default_nettype none
module gsr_host (
	input wire logic clk_sys,
	input wire logic slow,
	output var logic tx_ready = 1'h1
);
	always @(posedge clk_sys) tx_ready <= !slow || 1'($urandom_range(1));
endmodule : gsr_host
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import gsr_pkg::*;
	logic       clk_sys = 1'h0, resetn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, rd_d = 1'h0, slow = 1'h0;
	logic       bus_ren_n = 1'h1, bus_ifc_n = 1'h1, rx_valid = 1'h0, rx_atn = 1'h0, link_atn = 1'h1;
	logic       local_key = 1'h0, remote_key = 1'h0, tx_ready, tx_valid_ff, tx_last_ff, srq_o_ff;
	logic       srq_oe_n_ff, remote_led_ff, lockout_ff, key_accept_ff;
	logic [3:0] reg_addr = 4'h0;
	logic [4:0] dev_addr = 5'h00;
	logic [7:0] reg_wdata = 8'h00, rx_data = 8'h00, std_evt = 8'h00, op_cond = 8'h00;
	logic [7:0] reg_rdata_ff, tx_data_ff, v;
	logic [7:0] rq[$], tq[$];
	wire logic  key_press = 1'h0;
	wire logic [7:0] err_cond = 8'h00;
	int         errors = 0, n_tests = 0;
	gsr_remote_status u_gsr_remote_status (.*);
	gsr_host u_gsr_host (.*);
	initial forever #2.5 clk_sys = ~clk_sys;
	task automatic chk(string s, logic [7:0] e, logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	always @(posedge clk_sys) begin
		if (rd_d) chk("rdata", rq.pop_front(), reg_rdata_ff);
		if (tx_valid_ff && tx_ready) chk("tx", tq.pop_front(), tx_data_ff);
		rd_d <= reg_rd;
	end
	task automatic w(int n);
		repeat (n) @(posedge clk_sys);
	endtask : w
	task automatic rg(bit wr, logic [3:0] a, logic [7:0] d);
		@(posedge clk_sys);
		if (!wr) rq.push_back(d);
		reg_wr <= wr;
		reg_rd <= !wr;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'h0;
		reg_rd <= 1'h0;
	endtask : rg
	task automatic rx(bit atn, logic [7:0] b);
		@(posedge clk_sys);
		rx_valid <= 1'h1;
		rx_atn <= atn;
		link_atn <= atn;
		rx_data <= b;
		@(posedge clk_sys);
		rx_valid <= 1'h0;
	endtask : rx
	task automatic msg(string s);
		foreach (s[i]) rx(0, s[i]);
	endtask : msg
	task automatic pn(logic [1:0] e);
		w(8);
		chk("panel", {6'h00, e}, {6'h00, lockout_ff, remote_led_ff});
	endtask : pn
	task automatic pk(bit r);
		if (r) remote_key <= 1'h1;
		else local_key <= 1'h1;
		w(6);
		remote_key <= 1'h0;
		local_key <= 1'h0;
		w(6);
	endtask : pk
	task automatic evt;
		std_evt <= v;
		@(posedge clk_sys) std_evt <= v;
		@(posedge clk_sys) std_evt <= 8'h00;
	endtask : evt
	task automatic dec(logic [7:0] x);
		if (x > 99) tq.push_back(CH_ZERO + x / 100);
		if (x > 9) tq.push_back(CH_ZERO + x / 10 % 10);
		tq.push_back(CH_ZERO + x % 10);
		tq.push_back(CH_CR);
		tq.push_back(CH_LF);
	endtask : dec
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_of_test
	initial begin
		#50000;
		errors++;
		end_of_test();
	end
	initial begin
		void'($urandom(32'hF6E6));
		dev_addr = 5'($urandom_range(30, 1));
		v = 8'($urandom_range(255, 1));
		w(16);
		resetn <= 1'h1;
		rg(0, REG_ESE, 8'h00);
		rg(0, 4'hF, 8'h00);
		evt();
		rg(0, REG_ESR, v);
		rg(0, REG_ESR, 8'h00);
		op_cond <= v;
		rg(0, REG_OPC, v);
		rg(0, REG_OPV, v);
		op_cond <= 8'h00;
		rg(0, REG_OPC, 8'h00);
		rg(1, REG_ESE, 8'hFF);
		rg(1, REG_SRE, 8'h20);
		rg(0, REG_SRE, 8'h20);
		evt();
		rg(0, REG_STB, 8'h60);
		chk("srq", 8'h00, {7'h00, srq_oe_n_ff});
		rx(1, {LAG_PFX, dev_addr});
		msg("*SRE?;*ESR?\015\012");
		w(3);
		chk("idle", 8'h00, {7'h00, tx_valid_ff});
		rg(0, REG_STB, 8'h10);
		dec(v);
		slow <= 1'h1;
		rx(1, {TAG_PFX, dev_addr});
		link_atn <= 1'h0;
		w(40);
		rg(0, REG_STB, 8'h00);
		tq.push_back(8'h00);
		rx(1, CMD_SPE);
		link_atn <= 1'h0;
		w(20);
		rx(1, CMD_SPD);
		chk("spoll", 8'h00, {7'h00, tx_valid_ff});
		bus_ren_n <= 1'h0;
		pn(2'b01);
		rx(1, CMD_UNL);
		rx(1, CMD_GTL);
		pn(2'b01);
		rx(1, {LAG_PFX, dev_addr});
		rx(1, CMD_GTL);
		pn(2'b00);
		pk(1);
		pn(2'b01);
		pk(0);
		pn(2'b00);
		rx(1, CMD_LLO);
		pk(1);
		pk(0);
		pn(2'b11);
		bus_ren_n <= 1'h1;
		pn(2'b00);
		msg("*ESR?\012");
		dec(8'h00);
		rx(1, {TAG_PFX, dev_addr});
		link_atn <= 1'h0;
		w(2);
		bus_ifc_n <= 1'h0;
		w(4);
		bus_ifc_n <= 1'h1;
		link_atn <= 1'h0;
		w(12);
		chk("abort", 8'h00, {7'h00, tx_valid_ff});
		chk("srq_o", 8'h00, {7'h00, srq_o_ff});
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
